// >>> codec_pkg.sv
// What this block does
// R1 - Each word starts at frame fall, sixteen bits
// R2 - Reset gives coarse sampling with P of eight
// R3 - P below eight selects fine sampling via DLL
// R4 - M 1..128, N 1..16, P 1..8 held
// R5 - Host keeps clock over P within 10..25 MHz
// R6 - Host keeps divider product above cascade demand
// R7 - One bit picks FIR or IIR both paths
// R8 - FIR delays seventeen/sixteen samples, IIR negligible
// R9 - Decimate 128 to one, one word per frame
// R10 - Filter passbands track sample rate at 0.45
// R11 - ADC modulator ticks at 128 times rate
// R12 - Two-bit field sets DAC ratio 128/256/512
// R13 - Host limits ratios 512/256 by rate and M
// R14 - Interpolator ticks at selected DAC ratio
// R15 - Analog loopback wins; digital loops ADC to DAC
// R16 - Side-tone attenuates ADC, adds to DAC input
// R17 - ADC gain six bits, applied at zero crossing
// R18 - DAC gain and power applied at zero crossing
// R19 - Two bits select ADC source; outputs configured
// R20 - Bypass leaves sinc only, frame rate times four; code floors M/4 to at least one, so x4 only for M a multiple of four
// R21 - Codes 01/10 pick the two microphone modes
// R22 - Ratio codes 00/01/10, code 11 as 128
// R23 - Pending gain waits for next zero crossing
package codec_pkg;
   localparam int WORD_BITS = 16;
   localparam int FRAME_BITS = 16;
   // Register addresses on the plain register port
   localparam logic [3:0] ADDR_CTRL1 = 4'h1;
   localparam logic [3:0] ADDR_CTRL2 = 4'h2;
   localparam logic [3:0] ADDR_CTRL3 = 4'h3;
   localparam logic [3:0] ADDR_CLK_M = 4'h4;
   localparam logic [3:0] ADDR_GAIN_ADC = 4'h5;
   localparam logic [3:0] ADDR_GAIN_DAC = 4'h6;
   localparam logic [3:0] ADDR_SIDETONE = 4'h7;
   localparam logic [3:0] ADDR_ROUTING = 4'h8;
   localparam logic [3:0] ADDR_CLK_N = 4'h9;
   localparam logic [3:0] ADDR_CLK_P = 4'ha;
   localparam logic [3:0] ADDR_STATUS = 4'hb;
   // Field positions
   localparam int CTRL1_IIR = 5;
   localparam int CTRL1_ANALOG_LOOP = 2;
   localparam int CTRL1_DIGITAL_LOOP = 1;
   localparam int CTRL2_BYPASS = 6;
   localparam int CTRL3_ADC_PWRDN = 7;
   localparam int CTRL3_DAC_PWRDN = 6;
   localparam int CTRL3_OSR_LSB = 3;
   localparam int SIDETONE_LSB = 3;
   localparam int ROUTE_SEL_LSB = 1;
   localparam int ROUTE_OUT_LSB = 3;
   // Codes
   localparam logic [1:0] OSR_128 = 2'h0;
   localparam logic [1:0] OSR_256 = 2'h1;
   localparam logic [1:0] OSR_512 = 2'h2;
   localparam logic [1:0] SEL_DIFF_ONE = 2'h0;
   localparam logic [1:0] SEL_MIC_SELF_BIAS = 2'h1;
   localparam logic [1:0] SEL_MIC_PSEUDO_DIFF = 2'h2;
   localparam logic [1:0] SEL_DIFF_TWO = 2'h3;
   localparam logic [2:0] SIDETONE_MUTE = 3'h7;
   // Reset values, dividers stored as value minus one
   localparam logic [6:0] M_RESET = 7'h01;
   localparam logic [3:0] N_RESET = 4'h0;
   localparam logic [2:0] P_RESET = 3'h7;
   localparam logic [2:0] P_COARSE = 3'h7;
   localparam logic [14:0] BIT_PERIOD_RESET = 15'(
      (int'(M_RESET) + 1) * (int'(N_RESET) + 1) * (int'(P_RESET) + 1));
   // Rates and delays
   localparam int MOD_RATE = 128;
   localparam int BYPASS_FACTOR = 4;
   localparam int OSR_RATE_128 = 128;
   localparam int OSR_RATE_256 = 256;
   localparam int OSR_RATE_512 = 512;
   localparam logic [4:0] DELAY_DECIM_FIR = 5'h11;
   localparam logic [4:0] DELAY_INTERP_FIR = 5'h10;
   localparam int MIN_BIT_CYCLES = 16;
   typedef enum logic [1:0] {LINK_IDLE = 2'b00, LINK_SHIFT = 2'b01}
      link_state_t;
endpackage

// >>> codec_link_if.sv
`timescale 1ns/1ps
// Serial sample link between the codec and the DSP
interface codec_link_if;
   logic shift_clk;
   logic frame_strobe;
   logic dout;
   logic din;
   modport device (output shift_clk, output frame_strobe, output dout,
                   input din);
   modport dsp (input shift_clk, input frame_strobe, input dout,
                output din);
endinterface

// >>> codec_device_end.sv
`timescale 1ns/1ps
module codec_device_end
(
   input wire logic clock,
   input wire logic reset_n,
   codec_link_if.device link,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic [codec_pkg::WORD_BITS-1:0] adc_sample,
   input wire logic adc_zero_cross,
   input wire logic dac_zero_cross,
   output logic [codec_pkg::WORD_BITS-1:0] rx_word,
   output logic rx_valid,
   output logic [codec_pkg::WORD_BITS-1:0] dac_word,
   output logic sample_tick,
   output logic mod_tick,
   output logic dac_tick,
   output logic fine_mode,
   output logic filter_iir,
   output logic filter_bypass,
   output logic analog_loop,
   output logic [1:0] input_select,
   output logic [4:0] output_config,
   output logic [5:0] adc_gain,
   output logic [5:0] dac_gain,
   output logic adc_power_on,
   output logic dac_power_on,
   output logic [4:0] decim_delay,
   output logic [4:0] interp_delay
);
   import codec_pkg::*;

   logic [7:0] ctrl1, ctrl2, ctrl3, gain_adc_req, gain_dac_req;
   logic [7:0] sidetone, routing;
   logic [7:0] next_ctrl1, next_ctrl2, next_ctrl3, next_gain_adc_req;
   logic [7:0] next_gain_dac_req, next_sidetone, next_routing, next_rdata;
   logic [6:0] m_code, next_m_code;
   logic [3:0] n_code, next_n_code;
   logic [2:0] p_code, next_p_code;
   logic adc_pending, dac_pending, next_adc_pending, next_dac_pending;
   logic [5:0] next_adc_gain, next_dac_gain;
   logic next_dac_power_on;
   logic [14:0] bp, phase, next_bp, next_phase, target_bp;
   logic [3:0] bit_idx, next_bit_idx;
   logic next_shift_clk, next_frame_strobe, shift_clk, frame_strobe;
   logic [15:0] tx_shift, rx_shift, next_tx_shift, next_rx_shift;
   logic [15:0] next_rx_word, next_dac_word, rx_full;
   logic next_rx_valid, next_sample_tick, next_mod_tick, next_dac_tick;
   logic [19:0] mod_acc, dac_acc, next_mod_acc, next_dac_acc, frame_len;
   logic [20:0] mod_step, dac_step;
   logic [7:0] m_full, m_eff;
   logic [9:0] mod_rate, dac_rate;
   logic last, frame_start, dig_loop;
   logic signed [15:0] side, src;
   logic signed [16:0] mix;

   // Ratio per DAC field code; spare code falls back to the default
   function automatic logic [9:0] osr_rate(input logic [1:0] code);
      if (code == OSR_256)
         osr_rate = 10'(OSR_RATE_256);                      // [R22]
      else if (code == OSR_512)
         osr_rate = 10'(OSR_RATE_512);                      // [R22]
      else
         osr_rate = 10'(OSR_RATE_128);                      // [R12] [R22]
   endfunction

   // Fractional tick: spreads rate ticks evenly over one frame
   function automatic logic [20:0] tick_step(input logic [19:0] acc,
      input logic [9:0] rate, input logic [19:0] len);
      logic [19:0] sum;
      sum = acc + 20'(rate);
      if (sum >= len)
         tick_step = {1'b1, sum - len};
      else
         tick_step = {1'b0, sum};
   endfunction

   // Register file decode, read data one cycle after the strobe
   always_comb
   begin
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_ctrl3 = ctrl3;
      next_m_code = m_code;
      next_n_code = n_code;
      next_p_code = p_code;
      next_gain_adc_req = gain_adc_req;
      next_gain_dac_req = gain_dac_req;
      next_sidetone = sidetone;
      next_routing = routing;
      next_rdata = 8'h00;
      if (reg_write)
      begin
         if (reg_addr == ADDR_CTRL1)
            next_ctrl1 = reg_wdata;
         else if (reg_addr == ADDR_CTRL2)
            next_ctrl2 = reg_wdata;
         else if (reg_addr == ADDR_CTRL3)
            next_ctrl3 = reg_wdata;
         else if (reg_addr == ADDR_CLK_M)
            next_m_code = reg_wdata[6:0];                   // [R4]
         else if (reg_addr == ADDR_CLK_N)
            next_n_code = reg_wdata[3:0];                   // [R4]
         else if (reg_addr == ADDR_CLK_P)
            next_p_code = reg_wdata[2:0];                   // [R4]
         else if (reg_addr == ADDR_GAIN_ADC)
            next_gain_adc_req = {2'h0, reg_wdata[5:0]};
         else if (reg_addr == ADDR_GAIN_DAC)
            next_gain_dac_req = {2'h0, reg_wdata[5:0]};
         else if (reg_addr == ADDR_SIDETONE)
            next_sidetone = reg_wdata;
         else if (reg_addr == ADDR_ROUTING)
            next_routing = reg_wdata;
      end
      if (reg_read)
      begin
         if (reg_addr == ADDR_CTRL1)
            next_rdata = ctrl1;
         else if (reg_addr == ADDR_CTRL2)
            next_rdata = ctrl2;
         else if (reg_addr == ADDR_CTRL3)
            next_rdata = ctrl3;
         else if (reg_addr == ADDR_CLK_M)
            next_rdata = {1'b0, m_code};
         else if (reg_addr == ADDR_CLK_N)
            next_rdata = {4'h0, n_code};
         else if (reg_addr == ADDR_CLK_P)
            next_rdata = {5'h00, p_code};
         else if (reg_addr == ADDR_GAIN_ADC)
            next_rdata = gain_adc_req;
         else if (reg_addr == ADDR_GAIN_DAC)
            next_rdata = gain_dac_req;
         else if (reg_addr == ADDR_SIDETONE)
            next_rdata = sidetone;
         else if (reg_addr == ADDR_ROUTING)
            next_rdata = routing;
         else if (reg_addr == ADDR_STATUS)
            next_rdata = {5'h00, fine_mode, dac_pending, adc_pending};
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl1 <= 8'h00;
         ctrl2 <= 8'h00;
         ctrl3 <= 8'h00;
         m_code <= M_RESET;
         n_code <= N_RESET;
         p_code <= P_RESET;                                 // [R2]
         gain_adc_req <= 8'h00;
         gain_dac_req <= 8'h00;
         sidetone <= 8'(SIDETONE_MUTE) << SIDETONE_LSB;
         routing <= 8'h00;
         reg_rdata <= 8'h00;
      end
      else
      begin
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         ctrl3 <= next_ctrl3;
         m_code <= next_m_code;
         n_code <= next_n_code;
         p_code <= next_p_code;
         gain_adc_req <= next_gain_adc_req;
         gain_dac_req <= next_gain_dac_req;
         sidetone <= next_sidetone;
         routing <= next_routing;
         reg_rdata <= next_rdata;
      end
   end

   // Static configuration taken straight from register flops
   assign fine_mode = (p_code != P_COARSE);                 // [R3]
   assign filter_iir = ctrl1[CTRL1_IIR];                    // [R7]
   assign filter_bypass = ctrl2[CTRL2_BYPASS];              // [R20]
   assign analog_loop = ctrl1[CTRL1_ANALOG_LOOP];           // [R15]
   assign input_select = routing[ROUTE_SEL_LSB +: 2];       // [R19] [R21]
   assign output_config = routing[ROUTE_OUT_LSB +: 5];      // [R19]
   assign adc_power_on = ~ctrl3[CTRL3_ADC_PWRDN];
   // Filter engine is told its delay; IIR reports none
   assign decim_delay = filter_iir ? 5'h00 : DELAY_DECIM_FIR;   // [R8]
   assign interp_delay = filter_iir ? 5'h00 : DELAY_INTERP_FIR; // [R8]

   // Gains wait for a zero crossing so level steps make no click
   always_comb
   begin
      next_adc_pending = (adc_pending & ~adc_zero_cross) |
         (reg_write & (reg_addr == ADDR_GAIN_ADC));          // [R23]
      next_dac_pending = (dac_pending & ~dac_zero_cross) |
         (reg_write & (reg_addr == ADDR_GAIN_DAC));          // [R23]
      next_adc_gain = (adc_zero_cross & adc_pending) ?
         gain_adc_req[5:0] : adc_gain;                       // [R17]
      next_dac_gain = (dac_zero_cross & dac_pending) ?
         gain_dac_req[5:0] : dac_gain;                       // [R18]
      next_dac_power_on = dac_zero_cross ?
         ~ctrl3[CTRL3_DAC_PWRDN] : dac_power_on;             // [R18]
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         adc_pending <= 1'b0;
         dac_pending <= 1'b0;
         adc_gain <= 6'h00;
         dac_gain <= 6'h00;
         dac_power_on <= 1'b1;
      end
      else
      begin
         adc_pending <= next_adc_pending;
         dac_pending <= next_dac_pending;
         adc_gain <= next_adc_gain;
         dac_gain <= next_dac_gain;
         dac_power_on <= next_dac_power_on;
      end
   end

   // Frame timing and serial shifting; divider change lands at a frame
   always_comb
   begin
      m_full = {1'b0, m_code} + 8'h01;
      // Bypass quarters M, rounded down to at least one, so the frame comes four times as often only when M is a multiple of four
      m_eff = filter_bypass ? (m_full >> 2) : m_full;        // [R20] [R6]
      if (m_eff == 8'h00)
         m_eff = 8'h01;
      target_bp = 15'(m_eff) * (15'(n_code) + 15'h0001) *
         (15'(p_code) + 15'h0001);                           // [R2] [R3]
      last = (phase == bp - 15'h0001);
      frame_start = last && (bit_idx == 4'(FRAME_BITS - 1));
      next_phase = last ? 15'h0000 : phase + 15'h0001;
      next_bit_idx = last ? bit_idx + 4'h1 : bit_idx;        // [R1]
      next_bp = frame_start ? target_bp : bp;
      next_shift_clk = (next_phase < (next_bp >> 1));
      // Strobe falls exactly as bit zero begins
      next_frame_strobe = (next_bit_idx == 4'(FRAME_BITS - 1)); // [R1]
      dig_loop = ctrl1[CTRL1_DIGITAL_LOOP] & ~analog_loop;   // [R15]
      rx_full = {rx_shift[14:0], link.din};
      next_rx_shift = last ? rx_full : rx_shift;
      next_tx_shift = tx_shift;
      if (frame_start)
         next_tx_shift = adc_sample;                         // [R9]
      else if (last)
         next_tx_shift = {tx_shift[14:0], 1'b0};
      next_rx_word = frame_start ? rx_full : rx_word;
      next_rx_valid = frame_start;
      next_sample_tick = frame_start;
      // Side-tone: ADC shifted down and mixed, saturating
      if (sidetone[SIDETONE_LSB +: 3] == SIDETONE_MUTE)
         side = 16'sh0000;
      else
         side = $signed(adc_sample) >>>
            (sidetone[SIDETONE_LSB +: 3] + 3'h1);            // [R16]
      src = dig_loop ? $signed(adc_sample) : $signed(rx_full); // [R15]
      mix = {src[15], src} + {side[15], side};               // [R16]
      next_dac_word = dac_word;
      if (frame_start)
      begin
         if (mix[16] != mix[15])
            next_dac_word = mix[16] ? 16'h8000 : 16'h7fff;
         else
            next_dac_word = mix[15:0];
      end
      // Oversampled ticks, realigned at every frame start
      frame_len = {1'b0, bp, 4'h0};                          // [R10]
      mod_rate = filter_bypass ? 10'(MOD_RATE / BYPASS_FACTOR) :
         10'(MOD_RATE);                                      // [R11] [R9]
      dac_rate = osr_rate(ctrl3[CTRL3_OSR_LSB +: 2]) >>
         (filter_bypass ? 2 : 0);                            // [R14] [R12]
      mod_step = tick_step(mod_acc, mod_rate, frame_len);
      dac_step = tick_step(dac_acc, dac_rate, frame_len);
      next_mod_acc = frame_start ? 20'h00000 : mod_step[19:0];
      next_dac_acc = frame_start ? 20'h00000 : dac_step[19:0];
      next_mod_tick = frame_start | mod_step[20];
      next_dac_tick = frame_start | dac_step[20];
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bp <= BIT_PERIOD_RESET;
         phase <= 15'h0000;
         bit_idx <= 4'h0;
         shift_clk <= 1'b1;
         frame_strobe <= 1'b0;
         tx_shift <= 16'h0000;
         rx_shift <= 16'h0000;
         rx_word <= 16'h0000;
         rx_valid <= 1'b0;
         dac_word <= 16'h0000;
         sample_tick <= 1'b0;
         mod_acc <= 20'h00000;
         dac_acc <= 20'h00000;
         mod_tick <= 1'b0;
         dac_tick <= 1'b0;
      end
      else
      begin
         bp <= next_bp;
         phase <= next_phase;
         bit_idx <= next_bit_idx;
         shift_clk <= next_shift_clk;
         frame_strobe <= next_frame_strobe;
         tx_shift <= next_tx_shift;
         rx_shift <= next_rx_shift;
         rx_word <= next_rx_word;
         rx_valid <= next_rx_valid;
         dac_word <= next_dac_word;
         sample_tick <= next_sample_tick;
         mod_acc <= next_mod_acc;
         dac_acc <= next_dac_acc;
         mod_tick <= next_mod_tick;
         dac_tick <= next_dac_tick;
      end
   end

   assign link.shift_clk = shift_clk;
   assign link.frame_strobe = frame_strobe;
   assign link.dout = tx_shift[15];                          // [R1]
endmodule // codec_device_end

// >>> codec_dsp_end.sv
`timescale 1ns/1ps
module codec_dsp_end
(
   input wire logic clock,
   input wire logic reset_n,
   codec_link_if.dsp link,
   input wire logic [codec_pkg::WORD_BITS-1:0] tx_word,
   output logic [codec_pkg::WORD_BITS-1:0] rx_word,
   output logic rx_valid,
   output logic frame_seen,
   output logic busy
);
   import codec_pkg::*;

   localparam int SCK = 0;
   localparam int FSY = 1;
   localparam int DAT = 2;

   logic [2:0] pins, sync1, sync2, sync3, level, next_level;
   link_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [15:0] tx_shift, rx_shift, next_tx_shift, next_rx_shift;
   logic [15:0] next_rx_word;
   logic next_rx_valid, next_frame_seen;
   logic strobe_fall, sck_rise, sck_fall;

   assign pins = {link.dout, link.frame_strobe, link.shift_clk};

   // Three-stage sampling of each link pin; first stage feeds only second
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : pin_sync
         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
            begin
               // Idle pin levels, so no false edge follows reset
               sync1[g] <= (g == SCK);
               sync2[g] <= (g == SCK);
               sync3[g] <= (g == SCK);
            end
            else
            begin
               sync1[g] <= pins[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
            end
         end
      end
   endgenerate

   // A level counts once the last two stages agree
   always_comb
   begin
      next_level = level;
      for (int i = 0; i < 3; i++)
      begin
         if (sync2[i] == sync3[i])
            next_level[i] = sync3[i];
      end
      strobe_fall = level[FSY] & ~next_level[FSY];           // [R1]
      sck_rise = ~level[SCK] & next_level[SCK];
      sck_fall = level[SCK] & ~next_level[SCK];
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_tx_shift = tx_shift;
      next_rx_shift = rx_shift;
      next_rx_word = rx_word;
      next_rx_valid = 1'b0;
      next_frame_seen = strobe_fall;
      // Frame fall wins over the shift edge arriving with it
      if (strobe_fall)
      begin
         next_state = LINK_SHIFT;                            // [R1]
         next_bit_cnt = 4'h0;
         next_tx_shift = tx_word;
      end
      else
      begin
         case (state)
            LINK_SHIFT:
            begin
               if (sck_rise && bit_cnt != 4'h0)
                  next_tx_shift = {tx_shift[14:0], 1'b0};
               if (sck_fall)
               begin
                  next_rx_shift = {rx_shift[14:0], level[DAT]};
                  next_bit_cnt = bit_cnt + 4'h1;
                  if (bit_cnt == 4'(FRAME_BITS - 1))
                  begin
                     next_rx_word = {rx_shift[14:0], level[DAT]}; // [R1]
                     next_rx_valid = 1'b1;
                     next_state = LINK_IDLE;
                  end
               end
            end
            default:
               next_state = LINK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         level <= 3'h1;
         state <= LINK_IDLE;
         bit_cnt <= 4'h0;
         tx_shift <= 16'h0000;
         rx_shift <= 16'h0000;
         rx_word <= 16'h0000;
         rx_valid <= 1'b0;
         frame_seen <= 1'b0;
      end
      else
      begin
         level <= next_level;
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         tx_shift <= next_tx_shift;
         rx_shift <= next_rx_shift;
         rx_word <= next_rx_word;
         rx_valid <= next_rx_valid;
         frame_seen <= next_frame_seen;
      end
   end

   // Bit 15 first; shifted on each rise after bit zero
   assign link.din = tx_shift[15];
   assign busy = (state == LINK_SHIFT);
endmodule // codec_dsp_end

// >>> codec_link_checker.sv
`timescale 1ns/1ps
module codec_link_checker
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic shift_clk,
   input wire logic frame_strobe,
   input wire logic dout,
   input wire logic din
);
   logic seen;
   logic [4:0] rises;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // Rises per frame; the first frame after reset opens with no strobe fall, so skipped
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         seen <= 1'b0;
         rises <= 5'h0;
      end
      else if ($fell(frame_strobe))
      begin
         seen <= 1'b1;
         rises <= 5'h0;
      end
      else if ($rose(shift_clk))
         rises <= rises + 5'h1;
   end
   fall_at_bit_a: assert property ($fell(frame_strobe) |-> shift_clk)
      else $error("strobe fell off a bit start");
   frame_period_a: assert property
      ($fell(frame_strobe) |-> ##256 $fell(frame_strobe))
      else $error("frame not 256 cycles");
   strobe_width_a: assert property
      ($rose(frame_strobe) |-> $rose(shift_clk) ##16 $fell(frame_strobe))
      else $error("strobe not one bit wide");
   sclk_high_a: assert property
      ($rose(shift_clk) |-> shift_clk [*8] ##1 !shift_clk)
      else $error("shift clock high phase wrong");
   sclk_low_a: assert property
      ($fell(shift_clk) |-> !shift_clk [*8] ##1 shift_clk)
      else $error("shift clock low phase wrong");
   dout_hold_a: assert property
      ($fell(shift_clk) |-> $stable(dout) [*8])
      else $error("dout moved inside a bit");
   din_hold_a: assert property
      ($fell(shift_clk) |-> $stable(din) [*8])
      else $error("din moved before sampling");
   bit_count_a: assert property
      (seen && $fell(frame_strobe) |-> rises == 5'h0f && $rose(shift_clk))
      else $error("frame not sixteen bits");
endmodule // codec_link_checker

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import codec_pkg::*;
   logic clock, reset_n, wr, rd, azc, dzc, st, mt, dt, fine, iir, aloop;
   logic byp, apo, dpo;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rv8;
   logic [15:0] adc, tx, rx_d, rx_w, dac_word;
   logic [1:0] isel;
   logic [5:0] ag, dg;
   logic [4:0] dd, idl;
   int mismatches, samples_checked;
   codec_link_if lnk();
   codec_device_end u_codec_device_end(.clock(clock), .reset_n(reset_n),
      .link(lnk), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
      .reg_read(rd), .reg_rdata(rdata), .adc_sample(adc),
      .adc_zero_cross(azc), .dac_zero_cross(dzc), .rx_word(rx_d),
      .rx_valid(), .dac_word(dac_word), .sample_tick(st), .mod_tick(mt),
      .dac_tick(dt), .fine_mode(fine), .filter_iir(iir),
      .filter_bypass(byp), .analog_loop(aloop), .input_select(isel),
      .output_config(), .adc_gain(ag), .dac_gain(dg), .adc_power_on(apo),
      .dac_power_on(dpo), .decim_delay(dd), .interp_delay(idl));
   codec_dsp_end u_codec_dsp_end(.clock(clock), .reset_n(reset_n),
      .link(lnk), .tx_word(tx), .rx_word(rx_w), .rx_valid(),
      .frame_seen(), .busy());
   codec_link_checker u_codec_link_checker(.clock(clock),
      .reset_n(reset_n), .shift_clk(lnk.shift_clk),
      .frame_strobe(lnk.frame_strobe), .dout(lnk.dout), .din(lnk.din));
   // 20 MHz bench clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Compare after the edge's updates have landed
   task automatic chk(input string nm, input logic [15:0] e, g);
      #1;
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 rv8 = rdata;
   endtask
   // Counts frame starts; a stuck link ends the run
   task automatic frames(input int n);
      int k;
      k = 0;
      while (n > 0)
      begin
         @(negedge clock);
         k++;
         if (st === 1'b1)
            n--;
         if (k > 3000)
         begin
            mismatches++;
            test_done();
         end
      end
   endtask
   task automatic zc_pulse(input logic dac);
      @(posedge clock);
      azc <= !dac;
      dzc <= dac;
      @(posedge clock);
      azc <= 1'b0;
      dzc <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task automatic t_reset;
      chk("fine", 16'h0, 16'(fine));
      chk("decim delay", 16'h11, 16'(dd));
      chk("interp delay", 16'h10, 16'(idl));
      rreg(4'hf);
      chk("unmapped", 16'h0, 16'(rv8));
   endtask
   // Product stays 16 at every frame start, so link timing is unchanged
   task automatic t_fine;
      frames(1);
      wreg(ADDR_CLK_P, 8'h01);
      wreg(ADDR_CLK_M, 8'h07);
      chk("fine", 16'h1, 16'(fine));
      rreg(ADDR_STATUS);
      chk("status", 16'h4, 16'(rv8));
      wreg(ADDR_CLK_M, 8'h81);
      wreg(ADDR_CLK_P, 8'hff);
      chk("fine", 16'h0, 16'(fine));
   endtask
   task automatic t_filter;
      wreg(ADDR_CTRL1, 8'h20);
      chk("iir", 16'h1, 16'(iir));
      chk("decim delay", 16'h0, 16'(dd));
      chk("interp delay", 16'h0, 16'(idl));
      wreg(ADDR_CTRL1, 8'h00);
      chk("iir", 16'h0, 16'(iir));
   endtask
   task automatic t_gain;
      wreg(ADDR_GAIN_ADC, 8'hea);
      chk("adc gain", 16'h0, 16'(ag));
      zc_pulse(1'b0);
      chk("adc gain", 16'h2a, 16'(ag));
      wreg(ADDR_GAIN_DAC, 8'h15);
      zc_pulse(1'b0);
      chk("dac gain", 16'h0, 16'(dg));
      wreg(ADDR_CTRL3, 8'hc0);
      zc_pulse(1'b1);
      chk("dac gain", 16'h15, 16'(dg));
      chk("dac power", 16'h0, 16'(dpo));
      chk("adc power", 16'h0, 16'(apo));
      wreg(ADDR_CTRL3, 8'h00);
      chk("dac power", 16'h0, 16'(dpo));
      zc_pulse(1'b1);
      chk("dac power", 16'h1, 16'(dpo));
   endtask
   task automatic t_route;
      for (int s = 0; s < 4; s++)
      begin
         wreg(ADDR_ROUTING, {5'h0, 2'(s), 1'b0});
         chk("input select", 16'(s), 16'(isel));
      end
   endtask
   // Ticks over one frame, from the forced tick at a frame start
   task automatic count_ticks(output int m, output int d);
      frames(2);
      m = int'(mt);
      d = int'(dt);
      repeat (255)
      begin
         @(negedge clock);
         m += int'(mt);
         d += int'(dt);
      end
   endtask
   // Ratio 512 needs a longer frame than this divider setting gives
   task automatic t_osr;
      logic [1:0] c [3] = '{OSR_128, OSR_256, 2'h3};
      int e [3] = '{128, 256, 128};
      int m, d;
      for (int i = 0; i < 3; i++)
      begin
         wreg(ADDR_CTRL3, {3'h0, c[i], 3'h0});
         count_ticks(m, d);
         chk("mod ticks", 16'(MOD_RATE), 16'(m));
         chk("dac ticks", 16'(e[i]), 16'(d));
      end
   endtask
   // M of eight in bypass keeps the 256-cycle frame; both writes land
   // inside one frame so no odd divider is ever taken
   task automatic t_bypass;
      int m, d;
      frames(1);
      wreg(ADDR_CLK_M, 8'h07);
      wreg(ADDR_CTRL2, 8'h40);
      chk("bypass", 16'h1, 16'(byp));
      count_ticks(m, d);
      chk("mod ticks", 16'(MOD_RATE / BYPASS_FACTOR), 16'(m));
      chk("dac ticks", 16'(OSR_RATE_128 / BYPASS_FACTOR), 16'(d));
      frames(1);
      wreg(ADDR_CTRL2, 8'h00);
      wreg(ADDR_CLK_M, 8'h01);
      chk("bypass", 16'h0, 16'(byp));
   endtask
   task automatic t_loop;
      wreg(ADDR_CTRL1, 8'h02);
      frames(3);
      chk("dac word", adc, dac_word);
      chk("dsp rx", adc, rx_w);
      adc <= 16'h0200;
      tx <= 16'h0100;
      wreg(ADDR_SIDETONE, 8'h00);
      wreg(ADDR_CTRL1, 8'h06);
      frames(3);
      chk("analog loop", 16'h1, 16'(aloop));
      chk("device rx", 16'h0100, rx_d);
      chk("dac word", 16'h0200, dac_word);
   endtask
   initial
   begin
      mismatches = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      azc = 1'b0;
      dzc = 1'b0;
      adc = 16'hb3c5;
      tx = 16'h5a3c;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      t_fine();
      t_filter();
      t_gain();
      t_route();
      t_osr();
      t_bypass();
      t_loop();
      test_done();
   end
endmodule // tb
